// File: hw/chain_pkg.sv
`default_nettype none
package chain_pkg;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned REPLY_DELAY_NS = 1700;
  localparam int unsigned REPLY_CYC = (REPLY_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PASS_CYC = 8;
  localparam int unsigned CELLS = 12;
  localparam int unsigned FLAG_W = 11;
  localparam int unsigned PD_W = 5;
  localparam logic [5:0] ALL_NODES_ID = 6'h3F;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SUMMARY = 8'h04;
  localparam logic [7:0] OFS_AUX = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam int unsigned CTRL_END_BIT = 6;
  localparam int unsigned ST_FAULT = 3;
  localparam int unsigned ST_BADADDR = 4;
  localparam int unsigned ST_FAIL = 5;
  localparam int unsigned F_BAL_OC = 0;
  localparam int unsigned F_BAL_UC = 1;
  localparam int unsigned F_OV = 2;
  localparam int unsigned F_UV = 3;
  localparam int unsigned F_GLOBAL_LO = 4;
  localparam int unsigned F_REG_CRC = 8;
  localparam int unsigned F_INT_DATA = 9;
  localparam int unsigned F_SUPPLY_LOW = 10;
  localparam logic [2:0] CRC3_POLY = 3'h3;
  localparam logic [7:0] CRC8_POLY = 8'h2F;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 11'h000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } fsm_e;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic [5:0] id;
    logic [7:0] addr;
    logic [5:0] count;
    logic crc_ok;
    logic addr_bad;
    logic wr_fail;
  } req_s;

  typedef struct packed {
    logic is_write;
    logic [5:0] id;
    logic [7:0] addr;
    logic [15:0] data;
    logic [7:0] crc;
  } reply_s;

  typedef struct packed {
    fsm_e fsm;
    logic [15:0] wait_cnt;
    logic [5:0] left;
    logic [7:0] addr;
    logic is_wr;
    logic [7:0] status;
    logic tx_valid;
    reply_s tx_frame;
    logic dir_swap;
    logic sleep;
    logic [5:0] node_id;
    logic end_mark;
    logic [FLAG_W-1:0] flags;
    logic [2:0] aux;
    logic [CELLS-1:0] cell_block;
    logic [CELLS-1:0] bal_en;
    logic [PD_W-1:0] pd_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] chk_cnt;
    logic chk_start;
    logic [PASS_CYC-1:0] fwd;
  } state_s;

  function automatic logic is_protected(input logic [7:0] a);
    case (a)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A,
      8'h14, 8'h15, 8'h17, 8'h36, 8'h38, 8'h3A: is_protected = 1'b1;
      default: is_protected = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: hw/crc_unit.sv
`default_nettype none
module crc_unit #(
  parameter int unsigned DW = 14,
  parameter int unsigned CW = 3,
  parameter logic [CW-1:0] POLY = '0
) (
  input wire logic [DW-1:0] data,
  output logic [CW-1:0] crc
);
  always_comb begin
    crc = '0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (crc[CW-1] ^ data[i]) begin
        crc = {crc[CW-2:0], 1'b0} ^ POLY;
      end else begin
        crc = {crc[CW-2:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/chain_reply.sv
// Function
// - Send a write reply only after a write request with a good checksum.
// - Reply status bit 3 shows any fault set in the summary register.
// - Reply status bit 4 shows the write address was invalid.
// - Reply status bit 5 shows write failure, only for checksum-protected registers.
// - Write reply carries a 3-bit checksum, polynomial z3 + z + 1.
// - All-nodes write swaps receive and transmit roles after successful write.
// - On all-nodes write only the chain end node replies, after success.
// - Multiple read sends one frame per register, same node identifier.
// - All-nodes read replies come in ascending node identifier order.
// - All-nodes read replies carry own identifier and the common address.
// - Incoming bits are forwarded with a fixed pass-through latency.
// - Wait the turnaround delay before the first frame of each reply.
// - Per-cell faults set their flag and stop balancing of those cells.
// - Global faults set their flag and stop all balancing.
// - Supply faults set the supply-low flag and enter sleep; drift sleeps too.
// - Incoming checksum error returns both interfaces to default direction.
// - The listed configuration registers are checksum protected.
// - Register and trim checks run on a fixed hardware interval.
// - Register and trim check faults flag at first detection.
// - Thermal selector test choice enables internal pull-down switches.
`default_nettype none
module chain_reply #(
  parameter int unsigned SLOT_CYCLES = 1000,
  parameter int unsigned CHECK_CYCLES = 50000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire chain_pkg::req_s req,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data,
  output logic tx_valid,
  output var chain_pkg::reply_s tx_frame,
  input wire logic rx_bit,
  output logic fwd_bit,
  output logic if_swapped,
  input wire logic [chain_pkg::CELLS-1:0] evt_bal_oc,
  input wire logic [chain_pkg::CELLS-1:0] evt_bal_uc,
  input wire logic [chain_pkg::CELLS-1:0] evt_ov,
  input wire logic [chain_pkg::CELLS-1:0] evt_uv,
  input wire logic [3:0] evt_global,
  input wire logic [2:0] evt_sleep,
  input wire logic chk_reg_crc_bad,
  input wire logic chk_int_bad,
  output logic chk_start,
  input wire logic [chain_pkg::CELLS-1:0] bal_req,
  output logic [chain_pkg::CELLS-1:0] bal_en,
  output logic [chain_pkg::PD_W-1:0] pulldown_en,
  output logic sleep_req
);
  import chain_pkg::*;

  localparam int unsigned SW = 4 * CELLS + 8;

  if (SLOT_CYCLES < 1 || REPLY_CYC + 62 * SLOT_CYCLES > 65535 || CHECK_CYCLES < 2) begin : g_bad_param
    $error("chain_reply: slot or check interval out of range");
  end

  state_s s_reg;
  state_s s_next;
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [CELLS-1:0] oc_s, uc_s, ov_s, uv_s;
  logic [3:0] glob_s;
  logic [2:0] sleep_s;
  logic rx_s;
  logic [2:0] crc3;
  logic [7:0] crc8;
  logic [7:0] wr_status;
  logic wr_ok;
  logic addressed;
  logic bcast;

  // Analog comparators and the line receiver are asynchronous to ref_clk.
  assign pins_raw = {evt_bal_oc, evt_bal_uc, evt_ov, evt_uv, evt_global, evt_sleep, rx_bit};

  sync2 #(.W(SW)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {oc_s, uc_s, ov_s, uv_s, glob_s, sleep_s, rx_s} = pins_s;

  // The fault bit is taken at send time, and the checksum must cover exactly the bits that are sent.
  always_comb begin
    wr_status = s_reg.status;
    wr_status[ST_FAULT] = |s_reg.flags;
  end

  crc_unit #(.DW(14), .CW(3), .POLY(CRC3_POLY)) u_crc3 (
    .data({s_reg.node_id, wr_status}),
    .crc(crc3)
  );

  crc_unit #(.DW(30), .CW(8), .POLY(CRC8_POLY)) u_crc8 (
    .data({s_reg.node_id, s_reg.addr, rd_data}),
    .crc(crc8)
  );

  assign wr_ok = !req.addr_bad && !(req.wr_fail && is_protected(req.addr));
  assign addressed = (req.id == s_reg.node_id);
  assign bcast = (req.id == ALL_NODES_ID);

  always_comb begin
    s_next = s_reg;
    s_next.tx_valid = 1'b0;
    s_next.chk_start = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.fwd = {s_reg.fwd[PASS_CYC-2:0], rx_s};

    // Zero-wait APB slave: data and pready are prepared in the setup cycle.
    s_next.pready = psel && !penable;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CTRL: s_next.prdata = {25'h0000000, s_reg.end_mark, s_reg.node_id};
        OFS_SUMMARY: s_next.prdata = {21'h000000, s_reg.flags};
        OFS_AUX: s_next.prdata = {29'h00000000, s_reg.aux};
        OFS_STATE: s_next.prdata = {27'h0000000, s_reg.fsm, s_reg.sleep, s_reg.dir_swap};
        default: begin
          s_next.prdata = 32'h00000000;
          s_next.pslverr = 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      s_next.prdata = 32'h00000000;
      s_next.pslverr = !(paddr == OFS_CTRL || paddr == OFS_SUMMARY || paddr == OFS_AUX);
    end
    if (psel && penable && s_reg.pready && pwrite) begin
      case (paddr)
        OFS_CTRL: begin
          s_next.node_id = pwdata[5:0];
          s_next.end_mark = pwdata[CTRL_END_BIT];
        end
        OFS_SUMMARY: begin
          s_next.flags = s_reg.flags & ~pwdata[FLAG_W-1:0];
          if (|pwdata[F_UV:F_BAL_OC]) begin
            s_next.cell_block = '0;
          end
        end
        OFS_AUX: s_next.aux = pwdata[2:0];
        default: ;
      endcase
    end

    // Hardware sets are applied after the software clear so a same-cycle event wins.
    s_next.cell_block = s_next.cell_block | oc_s | uc_s | ov_s | uv_s;
    s_next.flags[F_BAL_OC] = s_next.flags[F_BAL_OC] | (|oc_s);
    s_next.flags[F_BAL_UC] = s_next.flags[F_BAL_UC] | (|uc_s);
    s_next.flags[F_OV] = s_next.flags[F_OV] | (|ov_s);
    s_next.flags[F_UV] = s_next.flags[F_UV] | (|uv_s);
    s_next.flags[F_GLOBAL_LO+3:F_GLOBAL_LO] = s_next.flags[F_GLOBAL_LO+3:F_GLOBAL_LO] | glob_s;
    s_next.flags[F_REG_CRC] = s_next.flags[F_REG_CRC] | chk_reg_crc_bad;
    s_next.flags[F_INT_DATA] = s_next.flags[F_INT_DATA] | chk_int_bad;
    s_next.flags[F_SUPPLY_LOW] = s_next.flags[F_SUPPLY_LOW] | sleep_s[0] | sleep_s[1];
    s_next.sleep = s_reg.sleep | (|sleep_s);

    // The check interval is a free-running counter, unrelated to any measurement schedule.
    if (s_reg.chk_cnt == 32'(CHECK_CYCLES - 1)) begin
      s_next.chk_cnt = 32'h00000000;
      s_next.chk_start = 1'b1;
    end else begin
      s_next.chk_cnt = s_reg.chk_cnt + 32'h00000001;
    end

    s_next.bal_en = bal_req & ~s_next.cell_block;
    if (|s_next.flags[F_INT_DATA:F_GLOBAL_LO] || s_next.sleep) begin
      s_next.bal_en = '0;
    end

    s_next.pd_en = '0;
    if (s_reg.aux != 3'h0 && s_reg.aux <= 3'(PD_W)) begin
      s_next.pd_en = PD_W'(1) << (s_reg.aux - 3'h1);
    end

    unique case (s_reg.fsm)
      ST_IDLE: begin
        if (req.valid && !req.crc_ok) begin
          s_next.dir_swap = 1'b0;
        end else if (req.valid && req.is_write) begin
          s_next.is_wr = 1'b1;
          s_next.addr = req.addr;
          s_next.left = 6'h01;
          s_next.status = '0;
          s_next.status[ST_BADADDR] = req.addr_bad;
          s_next.status[ST_FAIL] = req.wr_fail && is_protected(req.addr);
          s_next.wait_cnt = 16'(REPLY_CYC);
          if (bcast && wr_ok) begin
            s_next.dir_swap = !s_reg.dir_swap;
            if (s_reg.end_mark) begin
              s_next.fsm = ST_WAIT;
            end
          end else if (addressed) begin
            s_next.fsm = ST_WAIT;
          end
        end else if (req.valid && (addressed || bcast)) begin
          s_next.is_wr = 1'b0;
          s_next.addr = req.addr;
          s_next.fsm = ST_WAIT;
          if (bcast) begin
            s_next.left = 6'h01;
            s_next.wait_cnt = 16'(REPLY_CYC) + 16'(s_reg.node_id - 6'h01) * 16'(SLOT_CYCLES);
          end else begin
            s_next.left = (req.count == 6'h00) ? 6'h01 : req.count;
            s_next.wait_cnt = 16'(REPLY_CYC);
          end
        end
      end
      ST_WAIT: begin
        if (s_reg.wait_cnt <= 16'h0001) begin
          s_next.fsm = ST_SEND;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 16'h0001;
        end
      end
      ST_SEND: begin
        s_next.tx_valid = 1'b1;
        s_next.tx_frame.is_write = s_reg.is_wr;
        s_next.tx_frame.id = s_reg.node_id;
        s_next.tx_frame.addr = s_reg.addr;
        if (s_reg.is_wr) begin
          s_next.tx_frame.data = {8'h00, wr_status};
          s_next.tx_frame.crc = {5'h00, crc3};
          s_next.fsm = ST_IDLE;
        end else begin
          s_next.tx_frame.data = rd_data;
          s_next.tx_frame.crc = crc8;
          if (s_reg.left <= 6'h01) begin
            s_next.fsm = ST_IDLE;
          end else begin
            s_next.left = s_reg.left - 6'h01;
            s_next.addr = s_reg.addr + 8'h01;
            s_next.wait_cnt = 16'(SLOT_CYCLES);
            s_next.fsm = ST_WAIT;
          end
        end
      end
      default: s_next.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.fsm <= ST_IDLE;
      s_reg.flags <= FLAGS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign rd_addr = s_reg.addr;
  assign tx_valid = s_reg.tx_valid;
  assign tx_frame = s_reg.tx_frame;
  assign fwd_bit = s_reg.fwd[PASS_CYC-1];
  assign if_swapped = s_reg.dir_swap;
  assign chk_start = s_reg.chk_start;
  assign bal_en = s_reg.bal_en;
  assign pulldown_en = s_reg.pd_en;
  assign sleep_req = s_reg.sleep;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_silent_on_crc: assert property (
    s_reg.fsm == ST_IDLE && req.valid && !req.crc_ok |=> s_reg.fsm == ST_IDLE ##1 !tx_valid)
    else $error("reply started after request checksum failure");
  a_fault_bit: assert property (
    s_reg.fsm == ST_SEND && s_reg.is_wr |=> tx_frame.data[ST_FAULT] == (|$past(s_reg.flags)))
    else $error("fault status bit does not match summary flags");
  a_fail_protected: assert property (
    tx_valid && tx_frame.is_write && tx_frame.data[ST_FAIL] |-> is_protected(tx_frame.addr))
    else $error("write failure reported for unprotected register");
  a_crc3_width: assert property (
    tx_valid && tx_frame.is_write |-> tx_frame.crc[7:3] == 5'h00 && tx_frame.data[15:6] == 10'h000
    && tx_frame.data[2:0] == 3'h0)
    else $error("write reply carries bits outside status and 3-bit checksum");
  a_bcast_swap: assert property (
    s_reg.fsm == ST_IDLE && req.valid && req.crc_ok && req.is_write && bcast && wr_ok
    |=> if_swapped != $past(if_swapped))
    else $error("interfaces not swapped after all-nodes write");
  a_reply_id: assert property (
    tx_valid |-> tx_frame.id == s_reg.node_id)
    else $error("reply frame carries a foreign identifier");
  a_turnaround_gap: assert property (
    s_reg.fsm == ST_IDLE ##1 s_reg.fsm == ST_WAIT |-> !tx_valid [*8])
    else $error("reply sent before turnaround delay");
  a_crc_err_dir: assert property (
    s_reg.fsm == ST_IDLE && req.valid && !req.crc_ok |=> !if_swapped)
    else $error("interfaces not returned to default on checksum error");
  a_global_bal_off: assert property (
    |s_reg.flags[F_INT_DATA:F_GLOBAL_LO] |-> bal_en == '0)
    else $error("balancing active with global fault flag set");
  a_sleep_entry: assert property (
    |sleep_s |=> sleep_req && (!$past(sleep_s[0] | sleep_s[1]) || s_reg.flags[F_SUPPLY_LOW]))
    else $error("sleep or supply flag missing after supply fault");
  a_fwd_latency: assert property (
    rst_b [*8] |=> $past(rx_s, 8) == fwd_bit)
    else $error("pass-through latency wrong");
  a_end_only: assert property (
    s_reg.fsm == ST_IDLE && req.valid && req.crc_ok && req.is_write && bcast && !s_reg.end_mark
    |=> s_reg.fsm == ST_IDLE)
    else $error("all-nodes write reply started without end marker");
  a_bad_addr_bit: assert property (
    s_reg.fsm == ST_IDLE && req.valid && req.crc_ok && req.is_write && addressed
    |=> s_reg.status[ST_BADADDR] == $past(req.addr_bad))
    else $error("bad address status not captured");
  a_cell_block: assert property (
    |oc_s |=> (bal_en & $past(oc_s)) == '0)
    else $error("balancing left on for a cell with a current fault");
  a_reg_crc_flag: assert property (
    chk_reg_crc_bad |=> s_reg.flags[F_REG_CRC])
    else $error("register checksum fault not flagged at first detection");
  a_pulldown_onehot: assert property (
    $onehot0(pulldown_en))
    else $error("more than one pull-down switch enabled");

  c_bcast_write_reply: cover property (tx_valid && tx_frame.is_write && s_reg.end_mark);
  c_multi_read: cover property (tx_valid && !tx_frame.is_write ##[1:1000] tx_valid && !tx_frame.is_write);
  c_crc_fail: cover property (s_reg.fsm == ST_IDLE && req.valid && !req.crc_ok);
  c_sleep_entry: cover property (!sleep_req ##1 sleep_req);
endmodule
`default_nettype wire

// File: hw/sync2.sv
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule
`default_nettype wire

// File: tb/host_model.sv
`default_nettype none
module host_model (
  input wire logic ref_clk,
  output var chain_pkg::req_s req,
  output logic rx_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import chain_pkg::*;
  logic [16:0] lfsr = 17'h14E05;

  function automatic logic [16:0] step(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction

  initial req = '0;

  // The chain line toggles randomly so that pass-through latency is seen on every bit.
  always @(posedge ref_clk) begin
    lfsr <= step(lfsr);
  end
  assign rx_bit = lfsr[0];

  // Write flag leads the identifier, and all ones addresses every node.
  // A missing write reply leaves its entry in the reply queue, so the next reply is checked against it, or stop_test reports it as missing.
  // A reply from the chain end confirms an all-nodes write.
  task automatic send(input logic w, input logic [5:0] id, input logic [7:0] a, input logic [5:0] n,
                      input logic ok, input logic bad, input logic fail);
    req <= '{1'b1, w, id, a, n, ok, bad, fail};
    @(posedge ref_clk);
    req <= '{1'b0, ~w, ~id, ~a, ~n, ~ok, ~bad, ~fail};
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import chain_pkg::*;
  localparam int unsigned SLOT = 4;
  localparam int unsigned CHK = 20;
  localparam int unsigned FWD_LAT = PASS_CYC + 2;
  typedef struct packed {reply_s f; reply_s m; logic [31:0] at;} exp_s;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, tx_valid, rx_bit, fwd_bit, if_swapped;
  logic chk_reg_crc_bad, chk_int_bad, chk_start, sleep_req, fwd_on, err;
  logic [7:0] paddr, rd_addr;
  logic [31:0] pwdata, prdata, rd, t;
  logic [31:0] cyc = 0;
  logic [15:0] rd_data;
  logic [CELLS-1:0] evt_bal_oc, evt_bal_uc, evt_ov, evt_uv, bal_req, bal_en;
  logic [3:0] evt_global;
  logic [2:0] evt_sleep;
  logic [PD_W-1:0] pulldown_en;
  logic [FWD_LAT-1:0] hist = '0;
  logic [5:0] me = 6'h02;
  req_s req;
  reply_s tx_frame;
  exp_s q[$];
  exp_s x;
  int bad_count = 0;
  int n_checks = 0;

  assign rd_data = {8'hC3, rd_addr};

  chain_reply #(.SLOT_CYCLES(SLOT), .CHECK_CYCLES(CHK)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .rd_addr(rd_addr), .rd_data(rd_data), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .rx_bit(rx_bit), .fwd_bit(fwd_bit), .if_swapped(if_swapped), .evt_bal_oc(evt_bal_oc),
    .evt_bal_uc(evt_bal_uc), .evt_ov(evt_ov), .evt_uv(evt_uv), .evt_global(evt_global), .evt_sleep(evt_sleep),
    .chk_reg_crc_bad(chk_reg_crc_bad), .chk_int_bad(chk_int_bad), .chk_start(chk_start), .bal_req(bal_req),
    .bal_en(bal_en), .pulldown_en(pulldown_en), .sleep_req(sleep_req));
  host_model i_host (.ref_clk(ref_clk), .req(req), .rx_bit(rx_bit));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] crc(input logic [29:0] d, input int n, input logic [7:0] p, input int w);
    logic [7:0] c;
    logic fb;
    c = '0;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? p : 8'h00);
    end
    return c & ((8'h01 << w) - 8'h01);
  endfunction

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    chk("missing replies", 0, q.size());
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Replies are matched in order, both frame and arrival cycle.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    hist <= {hist[FWD_LAT-2:0], rx_bit};
    if (fwd_on) chk("fwd_bit", hist[FWD_LAT-1], fwd_bit);
    if (cyc > 32'd20000) begin
      bad_count++;
      stop_test();
    end
    if (tx_valid === 1'b1) begin
      if (q.size() == 0) begin
        chk("unexpected reply", 0, 1);
      end else begin
        x = q.pop_front();
        chk("reply frame", x.f & x.m, tx_frame & x.m);
        chk("reply cycle", x.at, cyc);
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle keeps a following call from driving psel twice in one time step.
    @(posedge ref_clk);
  endtask

  task automatic note(input logic w, input logic [7:0] a, input logic [7:0] st, input int lat);
    exp_s e;
    if (w) begin
      e.f = '{1'b1, me, 8'h00, {8'h00, st}, crc({16'h0, me, st}, 14, {5'h0, CRC3_POLY}, 3)};
      e.m = '{1'b1, 6'h3F, 8'h00, 16'h00FF, 8'h07};
    end else begin
      e.f = '{1'b0, me, a, {8'hC3, a}, crc({me, a, 8'hC3, a}, 30, CRC8_POLY, 8)};
      e.m = '1;
    end
    e.at = cyc + lat;
    q.push_back(e);
  endtask

  task automatic drain();
    for (int i = 0; i < 500 && q.size() > 0; i++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wreq(input logic [5:0] id, input logic [7:0] a, input logic bad, input logic fail,
                      input logic [7:0] st);
    note(1'b1, a, st, 88);
    i_host.send(1'b1, id, a, 6'h00, 1'b1, bad, fail);
    drain();
  endtask

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, fwd_on, chk_reg_crc_bad, chk_int_bad} = '0;
    {evt_bal_oc, evt_bal_uc, evt_ov, evt_uv, evt_global, evt_sleep, bal_req} = '0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (30) @(posedge ref_clk);
    fwd_on <= 1'b1;
    apb(1'b0, OFS_SUMMARY, 0);
    chk("summary reset", 0, rd);
    apb(1'b1, OFS_CTRL, 32'(me));
    apb(1'b0, 8'h10, 0);
    chk("unmapped", 1, err);
    $display("test registers done");
    wreq(me, 8'h01, 1'b0, 1'b1, 8'h20);
    wreq(me, 8'h16, 1'b0, 1'b1, 8'h00);
    wreq(me, 8'h50, 1'b1, 1'b0, 8'h10);
    i_host.send(1'b1, me, 8'h01, 6'h00, 1'b0, 1'b0, 1'b0);
    repeat (100) @(posedge ref_clk);
    $display("test write reply done");
    bal_req <= '1;
    evt_bal_oc <= 12'h008;
    repeat (6) @(posedge ref_clk);
    evt_bal_oc <= '0;
    chk("bal_en cell", 12'hFF7, bal_en);
    chk_reg_crc_bad <= 1'b1;
    @(posedge ref_clk);
    chk_reg_crc_bad <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("bal_en all", 0, bal_en);
    chk("no sleep", 0, sleep_req);
    apb(1'b0, OFS_SUMMARY, 0);
    chk("summary flags", 32'h101, rd);
    wreq(me, 8'h16, 1'b0, 1'b0, 8'h08);
    apb(1'b1, OFS_SUMMARY, 32'h101);
    repeat (3) @(posedge ref_clk);
    chk("bal_en freed", 12'hFFF, bal_en);
    $display("test diagnosis done");
    i_host.send(1'b1, ALL_NODES_ID, 8'h16, 6'h00, 1'b1, 1'b0, 1'b0);
    repeat (100) @(posedge ref_clk);
    chk("swapped", 1, if_swapped);
    apb(1'b0, OFS_STATE, 0);
    chk("state", 32'h5, rd);
    apb(1'b1, OFS_STATE, 0);
    chk("state read-only", 1, err);
    i_host.send(1'b1, me, 8'h16, 6'h00, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk("default direction", 0, if_swapped);
    apb(1'b1, OFS_CTRL, {25'h0, 1'b1, me});
    wreq(ALL_NODES_ID, 8'h16, 1'b0, 1'b0, 8'h00);
    $display("test all-nodes write done");
    for (int i = 0; i < 3; i++) note(1'b0, 8'h19 + 8'(i), 8'h00, 88 + i * (SLOT + 1));
    i_host.send(1'b0, me, 8'h19, 6'd3, 1'b1, 1'b0, 1'b0);
    drain();
    note(1'b0, 8'h20, 8'h00, 88 + SLOT);
    i_host.send(1'b0, ALL_NODES_ID, 8'h20, 6'd1, 1'b1, 1'b0, 1'b0);
    drain();
    $display("test reads done");
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, OFS_AUX, k);
      repeat (2) @(posedge ref_clk);
      chk("pulldown", (k >= 1 && k <= 5) ? (1 << (k - 1)) : 0, pulldown_en);
    end
    for (int i = 0; i < 100 && chk_start !== 1'b1; i++) @(posedge ref_clk);
    t = cyc;
    @(posedge ref_clk);
    for (int i = 0; i < 100 && chk_start !== 1'b1; i++) @(posedge ref_clk);
    chk("check interval", CHK, cyc - t);
    fwd_on <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      evt_sleep <= 3'(1 << k);
      repeat (6) @(posedge ref_clk);
      evt_sleep <= '0;
      chk("sleep", 1, sleep_req);
      apb(1'b0, OFS_SUMMARY, 0);
      chk("supply flag", (k < 2) ? 32'h400 : 32'h0, rd & 32'h400);
    end
    $display("test sleep done");
    stop_test();
  end
endmodule
`default_nettype wire
